// file: pkg/pciu_defs.vh
// constants for the pin change interrupt unit
// assumes a 32-bit ahb-lite slave port and 12-bit local decode
`ifndef PCIU_DEFS_VH
`define PCIU_DEFS_VH

// ************************************************************
// register indices and byte addresses (address = index * 4)
// ************************************************************
`define PCIU_IDX_GROUP_ENA  8'h68
`define PCIU_IDX_MASK0      8'h6B
`define PCIU_IDX_MASK1      8'h6C
`define PCIU_IDX_MASK2      8'h6D
`define PCIU_IDX_FLAGS      8'h70
`define PCIU_IDX_LEVEL0     8'h71
`define PCIU_IDX_LEVEL1     8'h72
`define PCIU_IDX_LEVEL2     8'h73
`define PCIU_ADDR_GROUP_ENA {2'b00, `PCIU_IDX_GROUP_ENA, 2'b00}
`define PCIU_ADDR_MASK0     {2'b00, `PCIU_IDX_MASK0, 2'b00}
`define PCIU_ADDR_MASK1     {2'b00, `PCIU_IDX_MASK1, 2'b00}
`define PCIU_ADDR_MASK2     {2'b00, `PCIU_IDX_MASK2, 2'b00}
`define PCIU_ADDR_FLAGS     {2'b00, `PCIU_IDX_FLAGS, 2'b00}
`define PCIU_ADDR_LEVEL0    {2'b00, `PCIU_IDX_LEVEL0, 2'b00}
`define PCIU_ADDR_LEVEL1    {2'b00, `PCIU_IDX_LEVEL1, 2'b00}
`define PCIU_ADDR_LEVEL2    {2'b00, `PCIU_IDX_LEVEL2, 2'b00}

// ************************************************************
// widths, field positions and reset values
// ************************************************************
`define PCIU_DEC_AW         12
`define PCIU_NGROUPS        3
`define PCIU_G0_PINS        8
`define PCIU_G1_PINS        7
`define PCIU_G2_PINS        8
`define PCIU_BIT_GROUP0     0
`define PCIU_BIT_GROUP1     1
`define PCIU_BIT_GROUP2     2
`define PCIU_RST_BYTE       8'h00
`define PCIU_RST_GROUPS     3'h0
`define PCIU_RST_WORD       32'h0000_0000
`define PCIU_HTRANS_NONSEQ  2'h2
`define PCIU_HRESP_OKAY     1'b0

`endif

// file: core/pciu_group.v
// one pin change group: synchroniser, change detect and sticky flag
// assumes pins are asynchronous and clear requests come from core_clk
`timescale 1ns/1ps
module pciu_group #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rst,
  // pins and configuration
  input  wire [WIDTH-1:0] pins,
  input  wire [WIDTH-1:0] mask,
  input  wire             grp_en,
  input  wire             flag_clr,
  // state
  output reg  [WIDTH-1:0] level_r,
  output reg              flag_r
);

  reg  [WIDTH-1:0] sync1_r;
  reg  [WIDTH-1:0] prev_r;
  wire             change;

  // ************************************************************
  // synchroniser and previous value
  // ************************************************************
  // two-flop synchroniser
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      sync1_r <= {WIDTH{1'b0}};
      level_r <= {WIDTH{1'b0}};
      prev_r  <= {WIDTH{1'b0}};
    end
    else
    begin
      sync1_r <= pins;
      level_r <= sync1_r;
      prev_r  <= level_r;
    end
  end

  assign change = grp_en & (|((level_r ^ prev_r) & mask));

  // ************************************************************
  // sticky flag, set wins over clear
  // ************************************************************
  // change sets flag
  always @(posedge core_clk)
  begin
    if (rst)
      flag_r <= 1'b0;
    else if (change)
      flag_r <= 1'b1;
    else if (flag_clr)
      flag_r <= 1'b0;
  end

endmodule

// file: core/pciu_top.v
// pin change interrupt unit: three pin groups behind an ahb-lite slave
// assumes single-clock system, pins asynchronous, cpu signals on core_clk
//
// Behaviour
// - group 2 pins 23..16 request group 2 vector when enabled globally
// - group 1 pins 14..8 request group 1 vector when enabled globally
// - group 0 pins 7..0 request group 0 vector when enabled globally
// - a triggering pin change sets its group's flag bit
// - vector requested only with flag, group enable and global enable
// - taking a group's vector clears that group's flag
// - writing one to a flag bit clears it, zero leaves it
// - flag register bits 7..3 read as zero
// - group 2 mask bits enable detection only with group 2 enable
// - group 1 mask has seven bits 6..0, gated by group 1 enable
// - group 1 mask bit 7 is read-only zero
// - group 0 mask bits enable detection only with group 0 enable
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "pciu_defs.vh"
module pciu_top #(
  parameter G0_PINS = `PCIU_G0_PINS,
  parameter G1_PINS = `PCIU_G1_PINS,
  parameter G2_PINS = `PCIU_G2_PINS
) (
  // clock and reset
  input  wire               core_clk,
  input  wire               rst,
  // ahb-lite slave
  input  wire               hsel,
  input  wire [31:0]        haddr,
  input  wire [1:0]         htrans,
  input  wire               hwrite,
  input  wire [2:0]         hsize,
  input  wire [31:0]        hwdata,
  input  wire               hready,
  output reg                hreadyout,
  output reg                hresp,
  output reg  [31:0]        hrdata,
  // pin inputs
  input  wire [G0_PINS-1:0] group0_pins,
  input  wire [G1_PINS-1:0] group1_pins,
  input  wire [G2_PINS-1:0] group2_pins,
  // cpu interrupt logic
  input  wire               global_int_en,
  input  wire [2:0]         vector_ack,
  output reg  [2:0]         group_vector_req,
  output reg                irq
);

  // ************************************************************
  // declarations
  // ************************************************************
  reg  [G0_PINS-1:0]    mask0_r;
  reg  [G0_PINS-1:0]    mask0_nxt;
  reg  [G1_PINS-1:0]    mask1_r;
  reg  [G1_PINS-1:0]    mask1_nxt;
  reg  [G2_PINS-1:0]    mask2_r;
  reg  [G2_PINS-1:0]    mask2_nxt;
  reg  [2:0]            group_ena_r;
  reg  [2:0]            group_ena_nxt;
  reg                   wr_pend_r;
  reg  [`PCIU_DEC_AW-1:0] wr_addr_r;
  reg  [31:0]           rd_data_nxt;
  reg  [2:0]            flag_clr;
  wire [2:0]            flags;
  wire [G0_PINS-1:0]    level0;
  wire [G1_PINS-1:0]    level1;
  wire [G2_PINS-1:0]    level2;
  wire                  addr_phase;
  wire                  rd_accept;
  wire                  wr_accept;
  wire [`PCIU_DEC_AW-1:0] dec_addr;
  wire [7:0]            wbyte;

  // ************************************************************
  // ahb-lite address phase decode
  // ************************************************************
  assign addr_phase = hsel & hready & (htrans == `PCIU_HTRANS_NONSEQ);
  assign rd_accept  = addr_phase & ~hwrite;
  assign wr_accept  = addr_phase & hwrite;
  assign dec_addr   = haddr[`PCIU_DEC_AW-1:0];
  assign wbyte      = hwdata[7:0];

  // write address is held into the data phase
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= {`PCIU_DEC_AW{1'b0}};
    end
    else
    begin
      wr_pend_r <= wr_accept;
      if (wr_accept)
        wr_addr_r <= dec_addr;
    end
  end

  // ************************************************************
  // configuration registers, written in the data phase
  // ************************************************************
  always @*
  begin
    mask0_nxt     = mask0_r;
    mask1_nxt     = mask1_r;
    mask2_nxt     = mask2_r;
    group_ena_nxt = group_ena_r;
    if (wr_pend_r)
    begin
      case (wr_addr_r)
        `PCIU_ADDR_MASK0:
          mask0_nxt = wbyte[G0_PINS-1:0];
        `PCIU_ADDR_MASK1:
          mask1_nxt = wbyte[G1_PINS-1:0];
        `PCIU_ADDR_MASK2:
          mask2_nxt = wbyte[G2_PINS-1:0];
        `PCIU_ADDR_GROUP_ENA:
          group_ena_nxt = wbyte[2:0];
        default:
          group_ena_nxt = group_ena_r;
      endcase
    end
  end

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      mask0_r     <= {G0_PINS{1'b0}};
      mask1_r     <= {G1_PINS{1'b0}};
      mask2_r     <= {G2_PINS{1'b0}};
      group_ena_r <= `PCIU_RST_GROUPS;
    end
    else
    begin
      mask0_r     <= mask0_nxt;
      mask1_r     <= mask1_nxt;
      mask2_r     <= mask2_nxt;
      group_ena_r <= group_ena_nxt;
    end
  end

  // ************************************************************
  // flag clear: write one or vector taken
  // ************************************************************
  always @*
  begin
    flag_clr = vector_ack;
    if (wr_pend_r && (wr_addr_r == `PCIU_ADDR_FLAGS))
      flag_clr = flag_clr | wbyte[2:0];
  end

  // ************************************************************
  // pin groups
  // ************************************************************
  // group 0 detection
  pciu_group #(
    .WIDTH    (G0_PINS)
  ) u_group0 (
    .core_clk (core_clk),
    .rst      (rst),
    .pins     (group0_pins),
    .mask     (mask0_r),
    .grp_en   (group_ena_r[`PCIU_BIT_GROUP0]),
    .flag_clr (flag_clr[`PCIU_BIT_GROUP0]),
    .level_r  (level0),
    .flag_r   (flags[`PCIU_BIT_GROUP0])
  );

  pciu_group #(
    .WIDTH    (G1_PINS)
  ) u_group1 (
    .core_clk (core_clk),
    .rst      (rst),
    .pins     (group1_pins),
    .mask     (mask1_r),
    .grp_en   (group_ena_r[`PCIU_BIT_GROUP1]),
    .flag_clr (flag_clr[`PCIU_BIT_GROUP1]),
    .level_r  (level1),
    .flag_r   (flags[`PCIU_BIT_GROUP1])
  );

  pciu_group #(
    .WIDTH    (G2_PINS)
  ) u_group2 (
    .core_clk (core_clk),
    .rst      (rst),
    .pins     (group2_pins),
    .mask     (mask2_r),
    .grp_en   (group_ena_r[`PCIU_BIT_GROUP2]),
    .flag_clr (flag_clr[`PCIU_BIT_GROUP2]),
    .level_r  (level2),
    .flag_r   (flags[`PCIU_BIT_GROUP2])
  );

  // ************************************************************
  // read data mux, sampled in the address phase
  // ************************************************************
  always @*
  begin
    rd_data_nxt = `PCIU_RST_WORD;
    case (dec_addr)
      `PCIU_ADDR_MASK0:
        rd_data_nxt[G0_PINS-1:0] = mask0_nxt;
      `PCIU_ADDR_MASK1:
        rd_data_nxt[G1_PINS-1:0] = mask1_nxt;
      `PCIU_ADDR_MASK2:
        rd_data_nxt[G2_PINS-1:0] = mask2_nxt;
      `PCIU_ADDR_GROUP_ENA:
        rd_data_nxt[2:0] = group_ena_nxt;
      `PCIU_ADDR_FLAGS:
        rd_data_nxt[2:0] = flags;
      `PCIU_ADDR_LEVEL0:
        rd_data_nxt[G0_PINS-1:0] = level0;
      `PCIU_ADDR_LEVEL1:
        rd_data_nxt[G1_PINS-1:0] = level1;
      `PCIU_ADDR_LEVEL2:
        rd_data_nxt[G2_PINS-1:0] = level2;
      default:
        rd_data_nxt = `PCIU_RST_WORD;
    endcase
  end

  // ************************************************************
  // bus response, zero wait states, always okay
  // ************************************************************
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp     <= `PCIU_HRESP_OKAY;
      hrdata    <= `PCIU_RST_WORD;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= `PCIU_HRESP_OKAY;
      if (rd_accept)
        hrdata <= rd_data_nxt;
    end
  end

  // ************************************************************
  // vector requests and interrupt line
  // ************************************************************
  // request: flag, enable and global enable; irq: flag and enable only
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      group_vector_req <= `PCIU_RST_GROUPS;
      irq              <= 1'b0;
    end
    else
    begin
      group_vector_req <= flags & group_ena_r & {3{global_int_en}};
      irq              <= |(flags & group_ena_r);
    end
  end

endmodule

// file: verif/pciu_monitor.sv
// port checker for the pin change unit
// assumes bind onto pciu_top, one clock
`timescale 1ns/1ps
module pciu_monitor #(
  parameter G0_PINS = 8,
  parameter G1_PINS = 7,
  parameter G2_PINS = 8
) (
  // clock and reset
  input wire               core_clk,
  input wire               rst,
  // bus
  input wire               hsel,
  input wire [31:0]        haddr,
  input wire [1:0]         htrans,
  input wire               hwrite,
  input wire               hready,
  input wire               hreadyout,
  input wire               hresp,
  input wire [31:0]        hrdata,
  // pins and cpu
  input wire [G0_PINS-1:0] group0_pins,
  input wire [G1_PINS-1:0] group1_pins,
  input wire [G2_PINS-1:0] group2_pins,
  input wire               global_int_en,
  input wire [2:0]         vector_ack,
  input wire [2:0]         group_vector_req,
  input wire               irq
);
  localparam W = G0_PINS + G1_PINS + G2_PINS;
  wire [W-1:0] pv = {group2_pins, group1_pins, group0_pins};
  reg  [W-1:0] q1_r;
  reg  [W-1:0] q2_r;
  reg  [W-1:0] q3_r;
  wire         quiet = (pv == q1_r) && (q1_r == q2_r) && (q2_r == q3_r);
  wire         rd = hsel && hready && htrans == 2'h2 && !hwrite;
  // *****
  // pin history
  // *****
  always @(posedge core_clk)
  begin
    q1_r <= pv;
    q2_r <= q1_r;
    q3_r <= q2_r;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_reset_clear: assert property (
    $past(rst) |-> !irq && group_vector_req == 3'h0)
    else $error("outputs not cleared by reset");
  a_req_gie: assert property (
    |group_vector_req |-> $past(global_int_en))
    else $error("request without global enable");
  a_req_irq: assert property (
    |group_vector_req |-> irq)
    else $error("request without irq");
  a_ack_clears: assert property (
    |vector_ack && quiet |-> ##2
    (group_vector_req & $past(vector_ack, 2)) == 3'h0)
    else $error("request stays after ack");
  a_flag_unused: assert property (
    rd && haddr[11:0] == 12'h1C0 |=> hrdata[31:3] == 29'h0)
    else $error("flag upper bits set");
  a_mask1_top: assert property (
    rd && haddr[11:0] == 12'h1B0 |=> hrdata[31:7] == 25'h0)
    else $error("mask1 bit 7 set");
endmodule
bind pciu_top pciu_monitor #(
  .G0_PINS(G0_PINS), .G1_PINS(G1_PINS), .G2_PINS(G2_PINS)
) u_mon (
  .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .group0_pins(group0_pins), .group1_pins(group1_pins),
  .group2_pins(group2_pins), .global_int_en(global_int_en),
  .vector_ack(vector_ack), .group_vector_req(group_vector_req),
  .irq(irq)
);

// file: verif/pin_change_interrupt_unit_tb_top.sv
// self-checking bench for the pin change unit
// assumes zero-wait ahb-lite slave, 10 MHz clock
`timescale 1ns/1ps
module pin_change_interrupt_unit_tb_top;
  reg         core_clk;
  reg         rst;
  reg         hsel;
  reg  [31:0] haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [31:0] hwdata;
  wire        hready;
  wire        hresp;
  wire [31:0] hrdata;
  reg  [7:0]  p0;
  reg  [6:0]  p1;
  reg  [7:0]  p2;
  reg         gie;
  reg  [2:0]  ack;
  wire [2:0]  req;
  wire        irq;
  reg  [31:0] rd;
  integer     err_count;
  integer     check_count;
  integer     g;
  pciu_top uut (
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .group0_pins(p0), .group1_pins(p1),
    .group2_pins(p2), .global_int_en(gie), .vector_ack(ack),
    .group_vector_req(req), .irq(irq)
  );
  // *****
  // helpers
  // *****
  task chk(input string nm, input [31:0] got, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("[FAIL] %0s exp %h got %h", nm, exp, got);
    end
  end
  endtask
  task rdy;
  begin
    @(posedge core_clk);
    while (hready !== 1'b1)
      @(posedge core_clk);
  end
  endtask
  task bus(input [11:0] a, input w, input [31:0] d);
  begin
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  end
  endtask
  task rchk(input [11:0] a, input [31:0] e);
  begin
    bus(a, 1'b0, 32'h0);
    chk("hrdata", rd, e);
  end
  endtask
  task tog(input integer gg, input integer b);
  begin
    if (gg == 0)
      p0[b] <= ~p0[b];
    else if (gg == 1)
      p1[b] <= ~p1[b];
    else
      p2[b] <= ~p2[b];
    repeat (6) @(posedge core_clk);
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // *****
  // clock, watchdog, tests
  // *****
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (3000) @(posedge core_clk);
    err_count = err_count + 1;
    end_sim;
  end
  initial
  begin
    err_count = 0;
    check_count = 0;
    {rst, hsel, haddr, htrans, hwrite, hwdata} = {1'b1, 68'h0};
    {p0, p1, p2, gie, ack} = 27'h0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (g = 0; g < 4; g = g + 1)
      rchk(12'h1AC + 12'h4 * g[11:0], 32'h0);
    rchk(12'h1A0, 32'h0);
    bus(12'h100, 1'b1, 32'hFF);
    rchk(12'h100, 32'h0);
    bus(12'h1AC, 1'b1, 32'hFF);
    bus(12'h1B0, 1'b1, 32'hFF);
    bus(12'h1B4, 1'b1, 32'hFF);
    bus(12'h1A0, 1'b1, 32'hFFFF_FFFF);
    rchk(12'h1B0, 32'h7F);
    rchk(12'h1AC, 32'hFF);
    rchk(12'h1B4, 32'hFF);
    rchk(12'h1A0, 32'h7);
    gie <= 1'b1;
    for (g = 0; g < 3; g = g + 1)
    begin
      tog(g, 3);
      chk("req", {29'h0, req}, 32'h1 << g);
      chk("irq", {31'h0, irq}, 32'h1);
      rchk(12'h1C0, 32'h1 << g);
      bus(12'h1C0, 1'b1, 32'h0);
      rchk(12'h1C0, 32'h1 << g);
      bus(12'h1C0, 1'b1, 32'h1 << g);
      rchk(12'h1C0, 32'h0);
    end
    tog(1, 6);
    ack <= 3'h2;
    @(posedge core_clk);
    ack <= 3'h0;
    repeat (2) @(posedge core_clk);
    chk("req", {29'h0, req}, 32'h0);
    rchk(12'h1C0, 32'h0);
    bus(12'h1AC, 1'b1, 32'hFE);
    tog(0, 0);
    rchk(12'h1C0, 32'h0);
    bus(12'h1A0, 1'b1, 32'h3);
    tog(2, 5);
    rchk(12'h1C0, 32'h0);
    gie <= 1'b0;
    tog(0, 1);
    chk("req", {29'h0, req}, 32'h0);
    chk("irq", {31'h0, irq}, 32'h1);
    rchk(12'h1C0, 32'h1);
    rchk(12'h1C4, 32'h0B);
    rchk(12'h1C8, 32'h48);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rchk(12'h1AC, 32'h0);
    rchk(12'h1A0, 32'h0);
    rchk(12'h1C0, 32'h0);
    end_sim;
  end
endmodule
